// ---- hw/comp_cal_host.sv ----
// Purpose: host end, sends one command with optional word, waits, reads answer if with_resp is set
// Assumes: user holds req until ack; opcode taken as given
// Notes:   wait times are module parameters so simulation can shorten them
`timescale 1ns/1ps
module comp_cal_host #(
  parameter int CMD_CYCLES   = comp_cal_pkg::CMD_CYC,    // plain wait
  parameter int RECAL_CYCLES = comp_cal_pkg::RECAL_CYC,  // recal wait
  parameter int STOP_CYCLES  = comp_cal_pkg::STOP_CYC    // stop hold-off
) (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        nrst,       // sync reset, active low
  comp_cal_if.host         lnk,        // link to sensor
  input  wire logic        req,        // start one command, level
  input  wire logic [15:0] opcode,     // command code
  input  wire logic        with_par,   // send parameter word
  input  wire logic        with_resp,  // read answer after wait
  input  wire logic [15:0] par,        // parameter word
  output logic             done,       // finished, pulse
  output logic [15:0]      resp,       // answer word
  output logic             resp_bad    // checksum or nack on answer
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SEND = 4'h2,
    H_WAIT = 4'h4,
    H_READ = 4'h8
  } hst_t;

  hst_t        st_r, st_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [39:0] sh_r, sh_nxt;
  logic [23:0] rx_r, rx_nxt;
  logic        hv_r, hv_nxt;
  logic [7:0]  hd_r, hd_nxt;
  logic        rq_r, rq_nxt;
  logic        done_r, done_nxt;
  logic [15:0] resp_r, resp_nxt;
  logic        bad_r, bad_nxt;
  logic        rd_r, rd_nxt;

  // sequencer: send bytes, wait the command time, then read if asked
  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    tmr_nxt  = tmr_r;
    sh_nxt   = sh_r;
    rx_nxt   = rx_r;
    hv_nxt   = 1'b0;
    hd_nxt   = hd_r;
    rq_nxt   = 1'b0;
    done_nxt = 1'b0;
    resp_nxt = resp_r;
    bad_nxt  = bad_r;
    rd_nxt   = rd_r;
    case (st_r)
      H_IDLE: begin
        if (req && !done_r) begin
          sh_nxt  = {opcode, par, comp_cal_pkg::crc8_byte(comp_cal_pkg::crc8_byte(
                     comp_cal_pkg::CRC_INIT, par[15:8]), par[7:0])};
          idx_nxt = with_par ? 3'd5 : 3'd2;
          rd_nxt  = with_resp;
          st_nxt  = H_SEND;
        end
      end
      H_SEND: begin
        hv_nxt  = 1'b1;
        hd_nxt  = sh_r[39:32];
        sh_nxt  = {sh_r[31:0], 8'h00};
        idx_nxt = idx_r - 3'd1;
        if (idx_r == 3'd1) begin
          st_nxt = H_WAIT;
          if (opcode == comp_cal_pkg::CMD_STOP)       tmr_nxt = 32'(STOP_CYCLES + 2);
          else if (opcode == comp_cal_pkg::CMD_RECAL) tmr_nxt = 32'(RECAL_CYCLES + 2);
          else                                        tmr_nxt = 32'(CMD_CYCLES + 2);
        end
      end
      H_WAIT: begin
        if (tmr_r == 32'd0) begin
          if (rd_r) begin
            rq_nxt  = 1'b1;
            idx_nxt = 3'd0;
            st_nxt  = H_READ;
          end else begin
            done_nxt = 1'b1;
            st_nxt   = H_IDLE;
          end
        end else begin
          tmr_nxt = tmr_r - 32'd1;
        end
      end
      H_READ: begin
        if (lnk.d2h_nack) begin
          bad_nxt  = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = H_IDLE;
        end else if (lnk.d2h_valid) begin
          rx_nxt  = {rx_r[15:0], lnk.d2h_data};
          idx_nxt = idx_r + 3'd1;
          if (idx_r == 3'd2) begin
            resp_nxt = rx_r[15:0];
            bad_nxt  = comp_cal_pkg::crc8_byte(comp_cal_pkg::crc8_byte(
                       comp_cal_pkg::CRC_INIT, rx_r[15:8]), rx_r[7:0]) != lnk.d2h_data;
            done_nxt = 1'b1;
            st_nxt   = H_IDLE;
          end
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r   <= H_IDLE;
      idx_r  <= 3'd0;
      tmr_r  <= 32'd0;
      sh_r   <= 40'h0;
      rx_r   <= 24'h0;
      hv_r   <= 1'b0;
      hd_r   <= 8'h00;
      rq_r   <= 1'b0;
      done_r <= 1'b0;
      resp_r <= 16'h0000;
      bad_r  <= 1'b0;
      rd_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      tmr_r  <= tmr_nxt;
      sh_r   <= sh_nxt;
      rx_r   <= rx_nxt;
      hv_r   <= hv_nxt;
      hd_r   <= hd_nxt;
      rq_r   <= rq_nxt;
      done_r <= done_nxt;
      resp_r <= resp_nxt;
      bad_r  <= bad_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign lnk.h2d_valid = hv_r;
  assign lnk.h2d_data  = hd_r;
  assign lnk.rd_req    = rq_r;
  assign done          = done_r;
  assign resp          = resp_r;
  assign resp_bad      = bad_r;
endmodule : comp_cal_host

// ---- hw/comp_cal_if.sv ----
// Purpose: byte link between host end and sensor end
// Assumes: one clock, valid-only bytes, at most one byte per cycle each way
// Notes:   host always writes, sensor answers only when host raises rd_req
`timescale 1ns/1ps
interface comp_cal_if;
  logic       h2d_valid;  // host byte strobe
  logic [7:0] h2d_data;   // host byte
  logic       rd_req;     // host asks for 3 response bytes
  logic       d2h_valid;  // sensor byte strobe
  logic [7:0] d2h_data;   // sensor byte
  logic       d2h_nack;   // sensor refuses read, pulse

  modport sensor (input h2d_valid, h2d_data, rd_req, output d2h_valid, d2h_data, d2h_nack);
  modport host   (output h2d_valid, h2d_data, rd_req, input d2h_valid, d2h_data, d2h_nack);
endinterface : comp_cal_if

// ---- hw/comp_cal_pkg.sv ----
// Purpose: shared constants for the compensation and calibration command path
// Assumes: 100 MHz clk_sys, byte-wide link between host end and sensor end
// Notes:   checksum is crc-8, polynomial 0x31, init 0xFF
package comp_cal_pkg;
  localparam logic [15:0] CMD_SET_ALT      = 16'h2427;
  localparam logic [15:0] CMD_GET_ALT      = 16'h2322;
  localparam logic [15:0] CMD_SET_PRESS    = 16'hE000;
  localparam logic [15:0] CMD_RECAL        = 16'h362F;
  localparam logic [15:0] CMD_STOP         = 16'h3F86;
  localparam logic [15:0] CMD_START        = 16'h21B1;
  localparam logic [15:0] ALT_RESET        = 16'h0000;
  localparam logic [15:0] RECAL_OFFSET     = 16'h8000;
  localparam logic [15:0] RECAL_FAIL       = 16'hFFFF;
  localparam logic [7:0]  CRC_INIT         = 8'hFF;
  localparam logic [7:0]  CRC_POLY         = 8'h31;
  localparam int          CLK_MHZ          = 100;
  localparam int          CMD_TIME_US      = 1000;
  localparam int          RECAL_TIME_US    = 400000;
  localparam int          STOP_TIME_US     = 500000;
  localparam int          CMD_CYC          = CMD_TIME_US * CLK_MHZ;
  localparam int          RECAL_CYC        = RECAL_TIME_US * CLK_MHZ;
  localparam int          STOP_CYC         = STOP_TIME_US * CLK_MHZ;

  // crc-8 over one byte, msb first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_byte
endpackage : comp_cal_pkg

// ---- hw/comp_cal_sensor.sv ----
// Purpose: sensor end, decodes altitude, pressure and reference recal commands
// Assumes: host keeps its own timing obligations; bytes arrive on clk_sys
// Notes:   recal correction is computed against a measured-value input
`timescale 1ns/1ps
module comp_cal_sensor #(
  parameter int RECAL_CYCLES = comp_cal_pkg::RECAL_CYC,  // recal busy time
  parameter int STOP_CYCLES  = comp_cal_pkg::STOP_CYC,   // stop busy time
  parameter int CMD_CYCLES   = comp_cal_pkg::CMD_CYC     // plain command time
) (
  input  wire logic        clk_sys,       // system clock
  input  wire logic        nrst,          // sync reset, active low
  comp_cal_if.sensor       lnk,           // link to host
  input  wire logic [15:0] measured_ppm,  // current raw concentration
  output logic [15:0]      altitude_m,    // stored altitude
  output logic [15:0]      pressure_hpa,  // stored pressure
  output logic             use_pressure,  // compensation by pressure
  output logic             measuring,     // measurement mode active
  output logic             busy,          // command executing
  output logic             crc_err        // checksum fault, pulse
);
  typedef enum logic [4:0] {
    S_CMD  = 5'h01,
    S_PAR  = 5'h02,
    S_EXEC = 5'h04,
    S_RESP = 5'h08,
    S_DONE = 5'h10
  } st_t;

  st_t         st_r, st_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [15:0] par_r, par_nxt;
  logic [15:0] resp_r, resp_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic        has_resp_r, has_resp_nxt;
  logic        ran_r, ran_nxt;
  logic [15:0] alt_r, alt_nxt;
  logic [15:0] prs_r, prs_nxt;
  logic        usep_r, usep_nxt;
  logic        meas_r, meas_nxt;
  logic        crcerr_r, crcerr_nxt;
  logic        dv_r, dv_nxt;
  logic [7:0]  dd_r, dd_nxt;
  logic        nack_r, nack_nxt;
  logic        busy_r, busy_nxt;
  logic [7:0]  resp_crc;
  logic        cmd_ok;

  assign resp_crc = comp_cal_pkg::crc8_byte(comp_cal_pkg::crc8_byte(
                    comp_cal_pkg::CRC_INIT, resp_r[15:8]), resp_r[7:0]);

  always_comb begin
    case (cmd_r)
      comp_cal_pkg::CMD_SET_PRESS: cmd_ok = 1'b1;
      comp_cal_pkg::CMD_STOP:      cmd_ok = 1'b1;
      default:                     cmd_ok = !meas_r;
    endcase
  end

  // command sequencer; commands with unknown codes are dropped silently
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    cmd_nxt      = cmd_r;
    par_nxt      = par_r;
    resp_nxt     = resp_r;
    tmr_nxt      = tmr_r;
    has_resp_nxt = has_resp_r;
    ran_nxt      = ran_r;
    alt_nxt      = alt_r;
    prs_nxt      = prs_r;
    usep_nxt     = usep_r;
    meas_nxt     = meas_r;
    crcerr_nxt   = 1'b0;
    dv_nxt       = 1'b0;
    dd_nxt       = dd_r;
    nack_nxt     = 1'b0;
    // reads outside a pending answer are refused
    if (lnk.rd_req && st_r != S_DONE) begin
      nack_nxt = 1'b1;
    end
    case (st_r)
      S_CMD: begin
        if (lnk.h2d_valid) begin
          cmd_nxt = {cmd_r[7:0], lnk.h2d_data};
          if (cnt_r == 2'd1) begin
            cnt_nxt = 2'd0;
            case ({cmd_r[7:0], lnk.h2d_data})
              comp_cal_pkg::CMD_SET_ALT, comp_cal_pkg::CMD_SET_PRESS,
              comp_cal_pkg::CMD_RECAL: begin
                st_nxt = S_PAR;
              end
              default: begin
                st_nxt = S_EXEC;
              end
            endcase
          end else begin
            cnt_nxt = 2'd1;
          end
        end
      end
      S_PAR: begin
        if (lnk.h2d_valid) begin
          if (cnt_r == 2'd2) begin
            cnt_nxt = 2'd0;
            if (comp_cal_pkg::crc8_byte(comp_cal_pkg::crc8_byte(comp_cal_pkg::CRC_INIT,
                par_r[15:8]), par_r[7:0]) == lnk.h2d_data) begin
              st_nxt = S_EXEC;
            end else begin
              crcerr_nxt = 1'b1;
              st_nxt     = S_CMD;
            end
          end else begin
            par_nxt = {par_r[7:0], lnk.h2d_data};
            cnt_nxt = cnt_r + 2'd1;
          end
        end
      end
      S_EXEC: begin
        if (tmr_r == 32'd0) begin
          has_resp_nxt = 1'b0;
          tmr_nxt      = 32'(CMD_CYCLES - 1);
          case (cmd_r)
            comp_cal_pkg::CMD_SET_ALT: if (cmd_ok) alt_nxt = par_r;
            comp_cal_pkg::CMD_GET_ALT: begin
              if (cmd_ok) begin
                resp_nxt     = alt_r;
                has_resp_nxt = 1'b1;
              end
            end
            comp_cal_pkg::CMD_SET_PRESS: begin
              prs_nxt  = par_r;
              usep_nxt = 1'b1;
            end
            comp_cal_pkg::CMD_RECAL: begin
              tmr_nxt      = 32'(RECAL_CYCLES - 1);
              has_resp_nxt = cmd_ok;
              if (!ran_r) begin
                resp_nxt = comp_cal_pkg::RECAL_FAIL;
              end else begin
                resp_nxt = 16'(par_r - measured_ppm + comp_cal_pkg::RECAL_OFFSET);
              end
            end
            comp_cal_pkg::CMD_STOP: begin
              meas_nxt = 1'b0;
              tmr_nxt  = 32'(STOP_CYCLES - 1);
            end
            comp_cal_pkg::CMD_START: begin
              meas_nxt = 1'b1;
              ran_nxt  = 1'b1;
            end
            default: tmr_nxt = 32'd1;
          endcase
          st_nxt = S_RESP;
        end else begin
          tmr_nxt = tmr_r - 32'd1;
        end
      end
      // busy time; bytes arriving now are ignored
      S_RESP: begin
        if (tmr_r == 32'd0) begin
          st_nxt = has_resp_r ? S_DONE : S_CMD;
        end else begin
          tmr_nxt = tmr_r - 32'd1;
        end
      end
      // answer held until read or a new command starts
      S_DONE: begin
        if (lnk.rd_req && cnt_r == 2'd0) begin
          cnt_nxt = 2'd1;
        end
        if (cnt_r != 2'd0) begin
          dv_nxt  = 1'b1;
          dd_nxt  = (cnt_r == 2'd1) ? resp_r[15:8] :
                    (cnt_r == 2'd2) ? resp_r[7:0] : resp_crc;
          cnt_nxt = (cnt_r == 2'd3) ? 2'd0 : cnt_r + 2'd1;
          if (cnt_r == 2'd3) st_nxt = S_CMD;
        end else if (lnk.h2d_valid) begin
          cmd_nxt = {8'h00, lnk.h2d_data};
          cnt_nxt = 2'd1;
          st_nxt  = S_CMD;
        end
      end
      default: st_nxt = S_CMD;
    endcase
    // busy registered from the next state, so it tracks the state register exactly
    busy_nxt = (st_nxt == S_EXEC) || (st_nxt == S_RESP);
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r       <= S_CMD;
      cnt_r      <= 2'd0;
      cmd_r      <= 16'h0000;
      par_r      <= 16'h0000;
      resp_r     <= 16'h0000;
      tmr_r      <= 32'd0;
      has_resp_r <= 1'b0;
      ran_r      <= 1'b0;
      alt_r      <= comp_cal_pkg::ALT_RESET;
      prs_r      <= 16'h0000;
      usep_r     <= 1'b0;
      meas_r     <= 1'b0;
      crcerr_r   <= 1'b0;
      dv_r       <= 1'b0;
      dd_r       <= 8'h00;
      nack_r     <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      cmd_r      <= cmd_nxt;
      par_r      <= par_nxt;
      resp_r     <= resp_nxt;
      tmr_r      <= tmr_nxt;
      has_resp_r <= has_resp_nxt;
      ran_r      <= ran_nxt;
      alt_r      <= alt_nxt;
      prs_r      <= prs_nxt;
      usep_r     <= usep_nxt;
      meas_r     <= meas_nxt;
      crcerr_r   <= crcerr_nxt;
      dv_r       <= dv_nxt;
      dd_r       <= dd_nxt;
      nack_r     <= nack_nxt;
      busy_r     <= busy_nxt;
    end
  end

  assign lnk.d2h_valid = dv_r;
  assign lnk.d2h_data  = dd_r;
  assign lnk.d2h_nack  = nack_r;
  assign altitude_m    = alt_r;
  assign pressure_hpa  = prs_r;
  assign use_pressure  = usep_r;
  assign measuring     = meas_r;
  assign busy          = busy_r;
  assign crc_err       = crcerr_r;
endmodule : comp_cal_sensor

// ---- verif/co2_compensation_calibration_cmds_bench.sv ----
// Purpose: self-checking bench, host end talking to sensor end
// Assumes: shortened wait counts on both ends and in the checker
// Notes:   second sensor fed raw bytes to inject checksum faults
`timescale 1ns/1ps
module co2_compensation_calibration_cmds_bench;
  localparam int CMD_N   = 10;  // plain command time
  localparam int RECAL_N = 50;  // recal time
  localparam int STOP_N  = 60;  // stop hold-off
  logic        clk_sys, nrst, req, with_par, with_resp, done, resp_bad;
  logic        use_press, meas, sbusy, crc_e, crc2, seen_crc, busy2;
  logic [15:0] opcode, par, resp, alt_m, press_hpa, ppm, alt2;
  logic [23:0] ans_w;
  int          error_cnt, cmp_count;
  int          cyc = 0;

  comp_cal_if lnk_if ();
  comp_cal_if l2 ();
  comp_cal_host #(.CMD_CYCLES(CMD_N), .RECAL_CYCLES(RECAL_N), .STOP_CYCLES(STOP_N))
    u_comp_cal_host (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk_if), .req(req),
    .opcode(opcode), .with_par(with_par), .with_resp(with_resp), .par(par),
    .done(done), .resp(resp), .resp_bad(resp_bad));
  comp_cal_sensor #(.RECAL_CYCLES(RECAL_N), .STOP_CYCLES(STOP_N), .CMD_CYCLES(CMD_N))
    u_comp_cal_sensor (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk_if), .measured_ppm(ppm),
    .altitude_m(alt_m), .pressure_hpa(press_hpa), .use_pressure(use_press),
    .measuring(meas), .busy(sbusy), .crc_err(crc_e));
  comp_cal_sensor #(.RECAL_CYCLES(RECAL_N), .STOP_CYCLES(STOP_N), .CMD_CYCLES(CMD_N))
    u_comp_cal_sensor_b (.clk_sys(clk_sys), .nrst(nrst), .lnk(l2),
    .measured_ppm(16'h0000), .altitude_m(alt2), .pressure_hpa(), .use_pressure(),
    .measuring(), .busy(busy2), .crc_err(crc2));
  comp_cal_monitor #(.CMD_CYCLES(CMD_N), .RECAL_CYCLES(RECAL_N), .STOP_CYCLES(STOP_N))
    u_comp_cal_monitor (.clk_sys(clk_sys), .nrst(nrst), .h2d_valid(lnk_if.h2d_valid),
    .h2d_data(lnk_if.h2d_data), .rd_req(lnk_if.rd_req), .d2h_valid(lnk_if.d2h_valid),
    .d2h_data(lnk_if.d2h_data), .d2h_nack(lnk_if.d2h_nack));

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // own checksum, bitwise, so it never shares code with the design
  function automatic logic [7:0] crc_calc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_calc

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // one host command, req held until the done pulse
  task cmd(input logic [15:0] op, input logic wp, input logic wr, input logic [15:0] p);
    int n;
    @(posedge clk_sys);
    #1;
    req = 1'b1;
    opcode = op;
    with_par = wp;
    with_resp = wr;
    par = p;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 400);
    req = 1'b0;
    chk({15'h0000, done}, 16'h0001);
  endtask : cmd

  // raw five-byte burst to the second sensor, data scrambled once released
  task raw5(input logic [39:0] v);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      #1;
      l2.h2d_valid = 1'b1;
      l2.h2d_data = v[39-8*i -: 8];
    end
    @(posedge clk_sys);
    #1;
    l2.h2d_valid = 1'b0;
    l2.h2d_data = ~l2.h2d_data;
  endtask : raw5

  // answer capture, fault flag and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (lnk_if.d2h_valid === 1'b1) ans_w <= {ans_w[15:0], lnk_if.d2h_data};
    if (crc2 === 1'b1) seen_crc <= 1'b1;
    if (nrst === 1'b1 && crc_e !== 1'b0) chk({15'h0000, crc_e}, 16'h0000);
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    nrst = 1'b0;
    req = 1'b0;
    opcode = 16'h0000;
    with_par = 1'b0;
    with_resp = 1'b0;
    par = 16'h0000;
    ppm = 16'h0212;
    l2.h2d_valid = 1'b0;
    l2.h2d_data = 8'h00;
    l2.rd_req = 1'b0;
    seen_crc = 1'b0;
    ans_w = 24'h000000;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    chk(alt_m, comp_cal_pkg::ALT_RESET);
    chk({15'h0000, use_press}, 16'h0000);
    cmd(comp_cal_pkg::CMD_GET_ALT, 1'b0, 1'b1, 16'h0000);
    chk(resp, comp_cal_pkg::ALT_RESET);
    // unknown code must leave the altitude alone
    cmd(16'h1234, 1'b0, 1'b0, 16'h0000);
    chk(alt_m, comp_cal_pkg::ALT_RESET);
    $display("test defaults done");
    cmd(comp_cal_pkg::CMD_SET_ALT, 1'b1, 1'b0, 16'h079E);
    chk(alt_m, 16'h079E);
    cmd(comp_cal_pkg::CMD_GET_ALT, 1'b0, 1'b1, 16'h0000);
    chk(resp, 16'h079E);
    chk(ans_w[23:8], 16'h079E);
    chk({8'h00, ans_w[7:0]}, 16'h0009);
    chk({15'h0000, resp_bad}, 16'h0000);
    $display("test altitude done");
    cmd(comp_cal_pkg::CMD_RECAL, 1'b1, 1'b1, 16'h01E0);
    chk(resp, comp_cal_pkg::RECAL_FAIL);
    $display("test recal fail done");
    // measuring: pressure taken, altitude and recal refused
    cmd(comp_cal_pkg::CMD_START, 1'b0, 1'b0, 16'h0000);
    chk({15'h0000, meas}, 16'h0001);
    cmd(comp_cal_pkg::CMD_SET_PRESS, 1'b1, 1'b0, 16'h03DB);
    chk(press_hpa, 16'h03DB);
    chk({15'h0000, use_press}, 16'h0001);
    cmd(comp_cal_pkg::CMD_SET_ALT, 1'b1, 1'b0, 16'h0400);
    chk(alt_m, 16'h079E);
    cmd(comp_cal_pkg::CMD_GET_ALT, 1'b0, 1'b1, 16'h0000);
    chk({15'h0000, resp_bad}, 16'h0001);
    cmd(comp_cal_pkg::CMD_RECAL, 1'b1, 1'b1, 16'h01E0);
    chk({15'h0000, resp_bad}, 16'h0001);
    $display("test measuring done");
    // stop then recal, 480 target against 530 measured is -50
    cmd(comp_cal_pkg::CMD_STOP, 1'b0, 1'b0, 16'h0000);
    chk({15'h0000, meas}, 16'h0000);
    cmd(comp_cal_pkg::CMD_RECAL, 1'b1, 1'b1, 16'h01E0);
    chk(resp, 16'h7FCE);
    chk({8'h00, ans_w[7:0]}, 16'h007B);
    $display("test recal done");
    nrst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    chk(alt_m, comp_cal_pkg::ALT_RESET);
    chk({15'h0000, use_press}, 16'h0000);
    chk({15'h0000, sbusy}, 16'h0000);
    $display("test reset done");
    // bad checksum dropped, good one taken
    raw5({comp_cal_pkg::CMD_SET_ALT, 16'h0123, crc_calc(16'h0123) ^ 8'h01});
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, seen_crc}, 16'h0001);
    chk(alt2, comp_cal_pkg::ALT_RESET);
    raw5({comp_cal_pkg::CMD_SET_ALT, 16'h0123, crc_calc(16'h0123)});
    chk({15'h0000, busy2}, 16'h0001);
    repeat (CMD_N + 4) @(posedge clk_sys);
    chk(alt2, 16'h0123);
    chk({15'h0000, busy2}, 16'h0000);
    $display("test checksum done");
    end_of_test();
  end
endmodule : co2_compensation_calibration_cmds_bench

// ---- verif/comp_cal_monitor.sv ----
// Purpose: protocol checker on the host-sensor byte link
// Assumes: one clock domain, wait counts equal on both ends
// Notes:   idle counter saturates, so long quiet spells never wrap
`timescale 1ns/1ps
module comp_cal_monitor #(
  parameter int CMD_CYCLES   = 10,  // plain command time
  parameter int RECAL_CYCLES = 50,  // recal time
  parameter int STOP_CYCLES  = 60   // stop hold-off
) (
  input wire logic       clk_sys,    // system clock
  input wire logic       nrst,       // sync reset, active low
  input wire logic       h2d_valid,  // host byte strobe
  input wire logic [7:0] h2d_data,   // host byte
  input wire logic       rd_req,     // answer request
  input wire logic       d2h_valid,  // sensor byte strobe
  input wire logic [7:0] d2h_data,   // sensor byte
  input wire logic       d2h_nack    // read refused
);
  logic [15:0] quiet_r;  // cycles since last host byte
  logic [2:0]  bcnt_r;   // byte index in a burst
  logic [15:0] op_r;     // last command code

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // track command code and idle time, burst index restarts on gaps
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      quiet_r <= 16'h0000;
      bcnt_r  <= 3'h0;
      op_r    <= 16'h0000;
    end else begin
      quiet_r <= h2d_valid ? 16'h0000 : (&quiet_r ? quiet_r : quiet_r + 16'h0001);
      bcnt_r  <= h2d_valid ? bcnt_r + 3'h1 : 3'h0;
      if (h2d_valid && bcnt_r == 3'h0) op_r[15:8] <= h2d_data;
      if (h2d_valid && bcnt_r == 3'h1) op_r[7:0] <= h2d_data;
    end
  end

  sequence s_answer;
    d2h_valid [*3] ##1 !d2h_valid;
  endsequence
  sequence s_set_alt;
    (h2d_valid && bcnt_r == 3'h0 && h2d_data == 8'h24) ##1 (h2d_valid && h2d_data == 8'h27);
  endsequence

  property p_ans_len;
    $rose(d2h_valid) |-> s_answer;
  endproperty
  property p_ans_cause;
    $rose(d2h_valid) |-> $past(rd_req, 2);
  endproperty
  property p_req_answered;
    rd_req |=> (d2h_nack or (##1 d2h_valid));
  endproperty
  property p_nack_cause;
    d2h_nack |-> $past(rd_req) && !d2h_valid;
  endproperty
  property p_set_silent;
    s_set_alt |=> !d2h_valid [*8];
  endproperty
  property p_cmd_wait;
    rd_req |-> quiet_r >= CMD_CYCLES - 1;
  endproperty
  property p_recal_wait;
    rd_req && op_r == comp_cal_pkg::CMD_RECAL |-> quiet_r >= RECAL_CYCLES - 1;
  endproperty
  property p_stop_quiet;
    h2d_valid && bcnt_r == 3'h0 && op_r == comp_cal_pkg::CMD_STOP |-> quiet_r >= STOP_CYCLES - 1;
  endproperty
  property p_burst;
    $rose(h2d_valid) |-> h2d_valid [*2] and bcnt_r == 3'h0;
  endproperty
  property p_burst_max;
    h2d_valid |-> bcnt_r < 3'h5 && !rd_req;
  endproperty

  a_ans_len: assert property (p_ans_len)
    else $error("answer not three bytes");
  a_ans_cause: assert property (p_ans_cause)
    else $error("answer without request");
  a_req_answered: assert property (p_req_answered)
    else $error("request left unanswered");
  a_nack_cause: assert property (p_nack_cause)
    else $error("stray refusal");
  a_set_silent: assert property (p_set_silent)
    else $error("set altitude answered");
  a_cmd_wait: assert property (p_cmd_wait)
    else $error("read before execution time");
  a_recal_wait: assert property (p_recal_wait)
    else $error("recal read too early");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("traffic inside stop hold-off");
  a_burst: assert property (p_burst)
    else $error("command code split");
  a_burst_max: assert property (p_burst_max)
    else $error("burst too long");
endmodule : comp_cal_monitor
